// file: inc/osvm_pkg.sv
// Purpose: constants shared by the output stage volume mixer
// Assumes: 8-bit registers at their printed offsets, 7-bit attenuation codes
// Notes:   gain table holds attenuation in tenths of a dB per code
package osvm_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W          = 7;                 // register address width
    localparam int          DATA_W          = 8;                 // register data width
    localparam logic [6:0]  LINE2_ROUTE_OFS = 7'h2d;             // left line input two route
    localparam logic [6:0]  GAIN_ROUTE_OFS  = 7'h2e;             // left input gain stage route
    localparam logic [6:0]  HP_LEVEL_OFS    = 7'h33;             // left headphone out level/status
    localparam logic [7:0]  ROUTE_RST       = 8'h00;             // route register reset value

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int          ROUTE_EN_BIT    = 7;                 // route connect bit
    localparam int          CODE_W          = 7;                 // attenuation code width
    localparam int          PENDING_BIT     = 1;                 // gain change pending status bit
    localparam logic [6:0]  CODE_ZERO_DB    = 7'h00;             // 0 dB code
    localparam logic [6:0]  CODE_LAST       = 7'h75;             // last attenuating code (117)
    localparam logic [6:0]  CODE_MUTE       = 7'h76;             // first mute code (118)

    // ----------------------------------------------------------------
    // gain arithmetic
    // ----------------------------------------------------------------
    localparam int          NUM_PATHS       = 2;                 // routes into left headphone out
    localparam int          SAMPLE_W        = 16;                // audio sample width
    localparam int          TENTHS_W        = 10;                // attenuation in 0.1 dB
    localparam int          MANT_W          = 16;                // linear gain, Q15
    localparam int          MANT_FRAC       = 15;                // fraction bits of linear gain
    localparam logic [9:0]  TENTHS_PER_6DB  = 10'h03c;           // one halving of amplitude
    localparam logic [9:0]  TENTHS_PER_STEP = 10'h005;           // half a dB

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ         = 125;               // clock rate
    localparam int          STEP_US         = 8;                 // time between soft gain steps
    localparam int          STEP_CYCLES     = STEP_US * CLK_MHZ; // cycles between steps

    // attenuation in tenths of a dB, codes 0 to 117
    localparam logic [9:0] GAIN_TENTHS [0:117] = '{
        10'd0,   10'd5,   10'd10,  10'd15,  10'd20,  10'd25,  10'd30,  10'd35,  10'd40,  10'd45,
        10'd50,  10'd55,  10'd60,  10'd65,  10'd70,  10'd75,  10'd80,  10'd85,  10'd90,  10'd95,
        10'd100, 10'd105, 10'd110, 10'd115, 10'd120, 10'd125, 10'd130, 10'd135, 10'd140, 10'd145,
        10'd150, 10'd155, 10'd160, 10'd165, 10'd170, 10'd175, 10'd180, 10'd186, 10'd191, 10'd196,
        10'd201, 10'd206, 10'd211, 10'd216, 10'd221, 10'd226, 10'd231, 10'd236, 10'd241, 10'd246,
        10'd251, 10'd256, 10'd261, 10'd266, 10'd271, 10'd276, 10'd281, 10'd286, 10'd291, 10'd296,
        10'd301, 10'd306, 10'd311, 10'd316, 10'd321, 10'd326, 10'd331, 10'd336, 10'd341, 10'd346,
        10'd351, 10'd357, 10'd361, 10'd367, 10'd371, 10'd377, 10'd382, 10'd387, 10'd392, 10'd397,
        10'd402, 10'd407, 10'd412, 10'd417, 10'd422, 10'd427, 10'd432, 10'd438, 10'd443, 10'd448,
        10'd452, 10'd458, 10'd462, 10'd467, 10'd474, 10'd479, 10'd482, 10'd487, 10'd493, 10'd500,
        10'd503, 10'd510, 10'd514, 10'd518, 10'd522, 10'd527, 10'd537, 10'd542, 10'd553, 10'd567,
        10'd583, 10'd602, 10'd627, 10'd643, 10'd662, 10'd687, 10'd722, 10'd783
    };

    // linear gain of each half-dB step inside one 6 dB octave, Q15
    localparam logic [15:0] MANT [0:11] = '{
        16'h8000, 16'h78d7, 16'h7215, 16'h6bb3, 16'h65ad, 16'h5ffd,
        16'h5a9e, 16'h558c, 16'h50c3, 16'h4c3f, 16'h47fb, 16'h43f4
    };

endpackage

// file: rtl/osvm_top.sv
// Contract
// - each route has own attenuator with mute
// - independent attenuator per source and destination
// - roughly half dB steps, coarser at end
// - fixed code table, 118 to 127 mute
// - line two register bit 7 connects
// - line two bits 6-0 attenuation code
// - gain stage register bit 7 connects
// - gain stage bits 6-0 readable writable code
// - both route registers reset to zero
// - status bit high while gain change pending
//
// Purpose: routing/volume registers and digital model of the left headphone mix
// Assumes: register port and sample inputs synchronous to MCLK_I
// Notes:   applied codes walk one step per STEP_CNT cycles (default STEP_CYCLES) toward the written code
`timescale 1ns/1ns
module osvm_top
    import osvm_pkg::*;
#(
    parameter int STEP_CNT = STEP_CYCLES                 // cycles between soft gain steps
) (
    input  wire logic                 MCLK_I,            // system clock
    input  wire logic                 RST_N_I,           // async reset, active low
    input  wire logic                 REG_WR_I,          // register write strobe
    input  wire logic                 REG_RD_I,          // register read strobe
    input  wire logic [ADDR_W-1:0]    REG_ADDR_I,        // register offset
    input  wire logic [DATA_W-1:0]    REG_WDATA_I,       // register write data
    input  wire logic                 SAMPLE_VALID_I,    // new input sample pair
    input  wire logic [SAMPLE_W-1:0]  LINE_TWO_SAMPLE_I, // left line input two sample
    input  wire logic [SAMPLE_W-1:0]  GAIN_STAGE_SAMPLE_I, // left input gain stage sample
    output logic      [DATA_W-1:0]    REG_RDATA_O,       // register read data
    output logic                      REG_RVALID_O,      // read data valid pulse
    output logic      [SAMPLE_W-1:0]  HP_SAMPLE_O,       // left headphone out mix
    output logic                      HP_VALID_O,        // mix valid pulse
    output logic                      HP_PENDING_O       // gain change still pending
);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // mute codes collapse onto the first mute code
    function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] c);
        clamp_code = (c > CODE_LAST) ? CODE_MUTE : c;
    endfunction

    // code to Q15 linear gain, zero for mute
    function automatic logic [MANT_W-1:0] code_to_lin(input logic [CODE_W-1:0] c);
        logic [TENTHS_W-1:0] att;
        logic [TENTHS_W-1:0] oct;
        logic [TENTHS_W-1:0] rem;
        att = '0;
        oct = '0;
        rem = '0;
        if (c > CODE_LAST) begin
            code_to_lin = '0;
        end else begin
            att = GAIN_TENTHS[c];
            oct = att / TENTHS_PER_6DB;
            rem = (att % TENTHS_PER_6DB) / TENTHS_PER_STEP;
            code_to_lin = MANT[rem[3:0]] >> oct;
        end
    endfunction

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;   // release shift register
    logic       rst_n;        // synchronised reset

    // two-flop release of the async reset
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // step timer
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_q;  // cycles since last step
    logic [31:0] tick_cnt_d;  // next count
    logic        step;        // one-cycle step strobe

    // free-running divider for the soft steps
    always_comb begin
        step       = (tick_cnt_q == 32'(STEP_CNT - 1));
        tick_cnt_d = step ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // per-path route register, applied code and contribution
    // ----------------------------------------------------------------
    localparam logic [6:0] PATH_OFS [0:NUM_PATHS-1] = '{LINE2_ROUTE_OFS, GAIN_ROUTE_OFS};

    logic [DATA_W-1:0]   route_q   [NUM_PATHS];  // route registers
    logic [CODE_W-1:0]   applied_q [NUM_PATHS];  // code now in effect
    logic [NUM_PATHS-1:0] busy;                  // path still stepping
    logic signed [SAMPLE_W+1:0] contrib [NUM_PATHS]; // scaled sample per path
    logic [SAMPLE_W-1:0] in_sample [NUM_PATHS];  // path input samples

    assign in_sample[0] = LINE_TWO_SAMPLE_I;
    assign in_sample[1] = GAIN_STAGE_SAMPLE_I;

    for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
        logic [DATA_W-1:0]   route_d;   // next route register
        logic [CODE_W-1:0]   applied_d; // next applied code
        logic [CODE_W-1:0]   target;    // written code, mute clamped
        logic signed [SAMPLE_W+MANT_W:0] prod; // sample times gain

        // register write and soft stepping toward the written code
        always_comb begin
            route_d   = route_q[p];
            if (REG_WR_I && (REG_ADDR_I == PATH_OFS[p])) begin
                route_d = REG_WDATA_I;
            end
            target    = clamp_code(route_q[p][CODE_W-1:0]);
            applied_d = applied_q[p];
            if (step && (applied_q[p] < target)) begin
                applied_d = applied_q[p] + 7'h01;
            end else if (step && (applied_q[p] > target)) begin
                applied_d = applied_q[p] - 7'h01;
            end
            busy[p] = (applied_q[p] != target);
        end

        always_ff @(posedge MCLK_I or negedge rst_n) begin
            if (!rst_n) begin
                route_q[p]   <= ROUTE_RST;
                applied_q[p] <= CODE_ZERO_DB;
            end else begin
                route_q[p]   <= route_d;
                applied_q[p] <= applied_d;
            end
        end

        always_comb begin
            prod = $signed(in_sample[p]) * $signed({1'b0, code_to_lin(applied_q[p])});
            if (route_q[p][ROUTE_EN_BIT]) begin
                contrib[p] = prod[SAMPLE_W+MANT_FRAC+1:MANT_FRAC];
            end else begin
                contrib[p] = '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // mix and saturate
    // ----------------------------------------------------------------
    logic signed [SAMPLE_W+1:0] mix_sum;        // sum of contributions
    logic [SAMPLE_W-1:0]        hp_sample_d;    // next mix output
    logic                       hp_valid_d;     // next valid
    logic                       hp_pending_d;   // next pending flag

    always_comb begin
        mix_sum = '0;
        for (int i = 0; i < NUM_PATHS; i++) begin
            mix_sum = mix_sum + contrib[i];
        end
        hp_sample_d = HP_SAMPLE_O;
        if (SAMPLE_VALID_I) begin
            if (mix_sum > 18'sh0_7fff) begin
                hp_sample_d = 16'h7fff;                 // clip high
            end else if (mix_sum < -18'sh0_8000) begin
                hp_sample_d = 16'h8000;                 // clip low
            end else begin
                hp_sample_d = mix_sum[SAMPLE_W-1:0];
            end
        end
        hp_valid_d   = SAMPLE_VALID_I;
        hp_pending_d = |busy;
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            HP_SAMPLE_O  <= 16'h0000;
            HP_VALID_O   <= 1'b0;
            HP_PENDING_O <= 1'b0;
        end else begin
            HP_SAMPLE_O  <= hp_sample_d;
            HP_VALID_O   <= hp_valid_d;
            HP_PENDING_O <= hp_pending_d;
        end
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] rdata_d;   // next read data
    logic              rvalid_d;  // next read valid

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d  = 8'h00;
        rvalid_d = REG_RD_I;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                LINE2_ROUTE_OFS: rdata_d = route_q[0];
                GAIN_ROUTE_OFS:  rdata_d = route_q[1];
                HP_LEVEL_OFS:    rdata_d[PENDING_BIT] = |busy;
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA_O  <= 8'h00;
            REG_RVALID_O <= 1'b0;
        end else begin
            REG_RDATA_O  <= rdata_d;
            REG_RVALID_O <= rvalid_d;
        end
    end

endmodule

// file: testbench/osvm_top_sva.sv
// Purpose: port-level assertions for the output stage volume mixer
// Assumes: one clock domain, reset from RST_N_I
// Notes:   bound into every osvm_top instance
`timescale 1ns/1ns
module osvm_top_sva
    import osvm_pkg::*;
#(
    parameter int STEP_CNT = STEP_CYCLES  // cycles between soft gain steps
) (
    input wire logic                MCLK_I,
    input wire logic                RST_N_I,
    input wire logic                REG_WR_I,
    input wire logic                REG_RD_I,
    input wire logic [ADDR_W-1:0]   REG_ADDR_I,
    input wire logic [DATA_W-1:0]   REG_WDATA_I,
    input wire logic                SAMPLE_VALID_I,
    input wire logic [SAMPLE_W-1:0] LINE_TWO_SAMPLE_I,
    input wire logic [SAMPLE_W-1:0] GAIN_STAGE_SAMPLE_I,
    input wire logic [DATA_W-1:0]   REG_RDATA_O,
    input wire logic                REG_RVALID_O,
    input wire logic [SAMPLE_W-1:0] HP_SAMPLE_O,
    input wire logic                HP_VALID_O,
    input wire logic                HP_PENDING_O
);
    // ------------------------------------------------------------
    // register port and mix path checks
    // ------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_N_I);

    a_read_answered: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read not answered next cycle");
    a_rvalid_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
        else $error("read valid without read");
    a_rdata_idle: assert property (!REG_RVALID_O |-> REG_RDATA_O == 8'h00)
        else $error("read data not zero when idle");
    a_unmapped_zero: assert property (REG_RD_I && !(REG_ADDR_I inside {7'h2d, 7'h2e, 7'h33})
        |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
    a_status_spare_zero: assert property (REG_RD_I && REG_ADDR_I == HP_LEVEL_OFS
        |=> (REG_RDATA_O & 8'hfd) == 8'h00) else $error("status spare bits set");
    a_line_two_back: assert property (REG_WR_I && REG_ADDR_I == LINE2_ROUTE_OFS ##1
        REG_RD_I && REG_ADDR_I == LINE2_ROUTE_OFS |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("line two route readback wrong");
    a_gain_stage_back: assert property (REG_WR_I && REG_ADDR_I == GAIN_ROUTE_OFS ##1
        REG_RD_I && REG_ADDR_I == GAIN_ROUTE_OFS |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
        else $error("gain stage route readback wrong");
    a_mix_valid_next: assert property (SAMPLE_VALID_I |=> HP_VALID_O)
        else $error("mix valid missing");
    a_mix_holds: assert property (!HP_VALID_O |-> $stable(HP_SAMPLE_O))
        else $error("mix changed without valid");
endmodule

bind osvm_top osvm_top_sva #(.STEP_CNT(STEP_CNT)) u_sva (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .SAMPLE_VALID_I(SAMPLE_VALID_I),
    .LINE_TWO_SAMPLE_I(LINE_TWO_SAMPLE_I), .GAIN_STAGE_SAMPLE_I(GAIN_STAGE_SAMPLE_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .HP_SAMPLE_O(HP_SAMPLE_O),
    .HP_VALID_O(HP_VALID_O), .HP_PENDING_O(HP_PENDING_O));

// file: testbench/osvm_top_tb.sv
// Purpose: self-checking bench for the output stage volume mixer
// Assumes: inputs driven on the falling edge, STEP_CNT shortened to 4
// Notes:   expected mix worked out from the package gain tables
`timescale 1ns/1ns
module osvm_top_tb
    import osvm_pkg::*;
();
    logic        mclk   = 1'b0;   // bench clock
    logic        rst_n  = 1'b0;   // bench reset
    logic        wr     = 1'b0;   // write strobe
    logic        rd     = 1'b0;   // read strobe
    logic        smp_v  = 1'b0;   // sample strobe
    logic [6:0]  addr   = 7'h00;  // register offset
    logic [7:0]  wdata  = 8'h00;  // write data
    logic [15:0] s_line = 16'h0000;
    logic [15:0] s_gain = 16'h0000;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [15:0] hp;
    logic        hp_v;
    logic        pend;
    int          errors = 0;
    int          checks = 0;
    logic [6:0]  codes [0:5] = '{7'h00, 7'h76, 7'h0c, 7'h25, 7'h75, 7'h7f};

    always #4 mclk = ~mclk;

    osvm_top #(.STEP_CNT(4)) u_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .SAMPLE_VALID_I(smp_v), .LINE_TWO_SAMPLE_I(s_line),
        .GAIN_STAGE_SAMPLE_I(s_gain), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .HP_SAMPLE_O(hp),
        .HP_VALID_O(hp_v), .HP_PENDING_O(pend));

    task automatic finish_test();
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t mix got %h exp %h", $time, got, exp);
        end
    endtask
    // each access starts and ends on a falling edge; a strobe stays up
    // across back-to-back calls of one kind and the next other call drops it
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        rd = 1'b0;
        smp_v = 1'b0;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge mclk);
    endtask
    task automatic reg_rd(input logic [6:0] a, input logic [7:0] exp);
        wr = 1'b0;
        smp_v = 1'b0;
        rd = 1'b1;
        addr = a;
        @(negedge mclk);
        chk_reg({7'h00, rvalid}, 8'h01);
        chk_reg(rdata, exp);
    endtask
    task automatic mix(input logic [15:0] a, input logic [15:0] b, input logic [15:0] exp);
        wr = 1'b0;
        rd = 1'b0;
        smp_v = 1'b1;
        s_line = a;
        s_gain = b;
        @(negedge mclk);
        chk_reg({7'h00, hp_v}, 8'h01);
        chk_smp(hp, exp);
    endtask
    // bounded wait for soft stepping to finish
    task automatic wait_idle();
        int n;
        n = 0;
        wr = 1'b0;
        rd = 1'b0;
        smp_v = 1'b0;
        while (pend !== 1'b0 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 2000) begin
            errors++;
            finish_test();
        end
    endtask
    // one route's share of the mix, zero when off or muted
    function automatic int term(input logic [15:0] s, input logic [7:0] r);
        int t;
        t = 0;
        if (r[7] && r[6:0] < CODE_MUTE) begin
            t = int'(GAIN_TENTHS[r[6:0]]);
            t = ($signed(s) * int'(MANT[(t % 60) / 5] >> (t / 60))) >>> 15;
        end
        return t;
    endfunction
    function automatic logic [15:0] sat(input int v);
        if (v > 32767) return 16'h7fff;
        if (v < -32768) return 16'h8000;
        return v[15:0];
    endfunction

    initial begin
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        reg_rd(LINE2_ROUTE_OFS, ROUTE_RST);
        reg_rd(GAIN_ROUTE_OFS, ROUTE_RST);
        reg_rd(HP_LEVEL_OFS, 8'h00);
        reg_wr(GAIN_ROUTE_OFS, 8'hd5);
        reg_rd(GAIN_ROUTE_OFS, 8'hd5);
        reg_rd(LINE2_ROUTE_OFS, 8'h00);
        reg_wr(7'h10, 8'hff);
        reg_rd(7'h10, 8'h00);
        wait_idle();
        reg_wr(HP_LEVEL_OFS, 8'hff);
        reg_rd(HP_LEVEL_OFS, 8'h00);
        reg_wr(GAIN_ROUTE_OFS, 8'h00);
        reg_rd(HP_LEVEL_OFS, 8'h02);
        wait_idle();
        // code table walk, gain stage off
        for (int i = 0; i < 6; i++) begin
            reg_wr(LINE2_ROUTE_OFS, {1'b1, codes[i]});
            reg_rd(HP_LEVEL_OFS, (i == 0) ? 8'h00 : 8'h02);
            chk_reg({6'h00, pend, 1'b0}, (i == 0) ? 8'h00 : 8'h02);
            reg_rd(LINE2_ROUTE_OFS, {1'b1, codes[i]});
            wait_idle();
            reg_rd(HP_LEVEL_OFS, 8'h00);
            mix(16'h4000, 16'h1234, sat(term(16'h4000, {1'b1, codes[i]})));
            mix(16'hc000, 16'h1234, sat(term(16'hc000, {1'b1, codes[i]})));
        end
        reg_wr(GAIN_ROUTE_OFS, 8'h8c);
        reg_wr(LINE2_ROUTE_OFS, 8'h80);
        reg_rd(HP_LEVEL_OFS, 8'h02);
        wait_idle();
        mix(16'h2000, 16'h2000, 16'h3000);
        mix(16'h7000, 16'h7000, 16'h7fff);
        mix(16'h9000, 16'h9000, 16'h8000);
        reg_wr(LINE2_ROUTE_OFS, 8'h00);
        mix(16'h7000, 16'h2000, 16'h1000);
        finish_test();
    end
endmodule
